// ---- design/dual_bus_shared_io_ports.sv ----
`timescale 1ns/1ps

// Summary of operation
// - Direction bit one makes pin input
// - Direction bit zero drives latch onto pin
// - Latch register reads return latched value
// - Pin register reads pins, writes latch
// - Low port is I/O only when bus disabled
// - High port is I/O only when bus disabled
// - Bus mode: low port carries low byte
// - Bus mode: high port carries bits 15:8
// - Low port multiplexed in 16-bit mode, else address
// - High port multiplexed in 16-bit mode, else address
// - Low port comes up in bus function
// - High port comes up in bus function
// - Direction registers reset to all ones
// - Latch kept across warm resets
// - Control register unimplemented bits read zero
module dual_bus_shared_io_ports (
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] low_port_pins_in,
  output logic [7:0] low_port_pins_out,
  output logic [7:0] low_port_pins_oe,
  input wire logic [7:0] high_port_pins_in,
  output logic [7:0] high_port_pins_out,
  output logic [7:0] high_port_pins_oe,
  input wire logic [15:0] sys_addr,
  input wire logic [15:0] sys_wdata,
  input wire logic sys_addr_phase,
  input wire logic sys_write,
  output logic [15:0] sys_rdata,
  output logic bus_enabled
);

  // --------------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------------
  typedef struct packed
  {
    gpio_pkg::apb_state_t apb;
    gpio_pkg::port_cfg_t low;
    gpio_pkg::port_cfg_t high;
    logic [7:0] bus_ctrl;
    logic wide_bus;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [15:0] sys_rdata;
    logic bus_en;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;
  gpio_pkg::sysbus_drive_t bus_drive;
  logic io_mode;
  logic apb_access;
  logic [7:0] wbyte;
  logic [15:0] pins_in;
  logic [15:0] pin_out;
  logic [15:0] pin_oe;
  logic [15:0] latch_all;
  logic [15:0] dir_all;

  // Port function exists only with the bus-disable bit set.
  assign io_mode = state_reg.bus_ctrl[gpio_pkg::BUS_DIS_POS];
  assign apb_access = psel && penable && (state_reg.apb == gpio_pkg::APB_IDLE);
  assign wbyte = pwdata[7:0];
  assign pins_in = {high_port_pins_in, low_port_pins_in};

  // Both ports side by side, high byte on top, in the order of the pins.
  assign latch_all = {state_reg.high.latch, state_reg.low.latch};
  assign dir_all = {state_reg.high.dir, state_reg.low.dir};

  // --------------------------------------------------------------------------
  // System bus drive.
  // --------------------------------------------------------------------------
  // Address phase drives all sixteen lines. In 16-bit mode the same lines
  // carry write data afterwards; in 8-bit mode they hold the address only,
  // so data never turns the pins around there.
  always_comb
  begin
    bus_drive.out = sys_addr;
    bus_drive.oe = 16'hFFFF;
    if (!sys_addr_phase)
    begin
      if (state_reg.wide_bus)
      begin
        bus_drive.out = sys_wdata;
        bus_drive.oe = sys_write ? 16'hFFFF : 16'h0000;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register file and APB slave.
  // --------------------------------------------------------------------------
  // One-cycle access phase: pready rises in the cycle after penable.
  always_comb
  begin
    state_next = state_reg;
    state_next.ready = 1'b0;
    state_next.err = 1'b0;
    state_next.bus_en = ~io_mode;
    // Data read back in bus mode is the sampled pin level of both bytes.
    state_next.sys_rdata = pins_in;
    if (state_reg.apb == gpio_pkg::APB_DONE)
    begin
      state_next.apb = gpio_pkg::APB_IDLE;
    end
    if (apb_access)
    begin
      state_next.apb = gpio_pkg::APB_DONE;
      state_next.ready = 1'b1;
      state_next.rdata = 32'h0000_0000;
      case (paddr)
        gpio_pkg::ADDR_LOW_PINS:
        begin
          state_next.rdata[7:0] = low_port_pins_in;
          if (pwrite)
          begin
            state_next.low.latch = wbyte;
          end
        end
        gpio_pkg::ADDR_LOW_LATCH:
        begin
          state_next.rdata[7:0] = state_reg.low.latch;
          if (pwrite)
          begin
            state_next.low.latch = wbyte;
          end
        end
        gpio_pkg::ADDR_LOW_DIR:
        begin
          state_next.rdata[7:0] = state_reg.low.dir;
          if (pwrite)
          begin
            state_next.low.dir = wbyte;
          end
        end
        gpio_pkg::ADDR_HIGH_PINS:
        begin
          state_next.rdata[7:0] = high_port_pins_in;
          if (pwrite)
          begin
            state_next.high.latch = wbyte;
          end
        end
        gpio_pkg::ADDR_HIGH_LATCH:
        begin
          state_next.rdata[7:0] = state_reg.high.latch;
          if (pwrite)
          begin
            state_next.high.latch = wbyte;
          end
        end
        gpio_pkg::ADDR_HIGH_DIR:
        begin
          state_next.rdata[7:0] = state_reg.high.dir;
          if (pwrite)
          begin
            state_next.high.dir = wbyte;
          end
        end
        gpio_pkg::ADDR_BUS_CTRL:
        begin
          state_next.rdata[7:0] = state_reg.bus_ctrl;
          if (pwrite)
          begin
            state_next.bus_ctrl = wbyte & gpio_pkg::BUS_CTRL_MASK;
          end
        end
        gpio_pkg::ADDR_STATUS:
        begin
          state_next.rdata[gpio_pkg::WIDE_BUS_POS] = state_reg.wide_bus;
          state_next.rdata[1] = ~io_mode;
          if (pwrite)
          begin
            state_next.wide_bus = wbyte[gpio_pkg::WIDE_BUS_POS];
          end
        end
        default:
        begin
          state_next.err = 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State register.
  // --------------------------------------------------------------------------
  // Every reset restores direction and control; only power-on clears the
  // latch. A warm reset keeps it so outputs reappear unchanged once software
  // sets the bus-disable bit and clears the direction bits again.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg.apb <= gpio_pkg::APB_IDLE;
      state_reg.low.dir <= gpio_pkg::DIR_RESET;
      state_reg.high.dir <= gpio_pkg::DIR_RESET;
      state_reg.bus_ctrl <= gpio_pkg::BUS_CTRL_RESET;
      state_reg.wide_bus <= gpio_pkg::WIDE_BUS_RESET;
      state_reg.rdata <= 32'h0000_0000;
      state_reg.ready <= 1'b0;
      state_reg.err <= 1'b0;
      state_reg.sys_rdata <= 16'h0000;
      state_reg.bus_en <= 1'b1;
      if (por)
      begin
        state_reg.low.latch <= gpio_pkg::LATCH_POWER_ON;
        state_reg.high.latch <= gpio_pkg::LATCH_POWER_ON;
      end
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------------
  // Pin selection.
  // --------------------------------------------------------------------------
  pin_mux #(
    .WIDTH(16)
  ) u_pin_mux (
    .clk(clk),
    .rst(rst),
    .io_mode(io_mode),
    .latch(latch_all),
    .dir(dir_all),
    .bus_out(bus_drive.out),
    .bus_oe(bus_drive.oe),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  assign low_port_pins_out = pin_out[7:0];
  assign low_port_pins_oe = pin_oe[7:0];
  assign high_port_pins_out = pin_out[15:8];
  assign high_port_pins_oe = pin_oe[15:8];
  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = state_reg.err;
  assign sys_rdata = state_reg.sys_rdata;
  assign bus_enabled = state_reg.bus_en;

  // --------------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------------
  chk_input_release: assert property (@(posedge clk) disable iff (rst)
    ($past(io_mode) && $past(state_reg.low.dir[0]) && io_mode) |-> !low_port_pins_oe[0])
    else $error("Input pin is still driven.");

  chk_output_latch: assert property (@(posedge clk) disable iff (rst)
    (io_mode && state_reg.low.dir == 8'h00) ##1 (io_mode && $stable(state_reg.low.latch))
      |-> low_port_pins_oe == 8'hFF && low_port_pins_out == state_reg.low.latch)
    else $error("Output pin does not show the latch.");

  chk_latch_readback: assert property (@(posedge clk) disable iff (rst)
    (apb_access && !pwrite && paddr == gpio_pkg::ADDR_LOW_LATCH)
      |=> pready && prdata[7:0] == $past(state_reg.low.latch))
    else $error("Latch read does not return the latch.");

  chk_pin_write: assert property (@(posedge clk) disable iff (rst)
    (apb_access && pwrite && paddr == gpio_pkg::ADDR_HIGH_PINS)
      |=> state_reg.high.latch == $past(pwdata[7:0]))
    else $error("Pin register write missed the latch.");

  chk_bus_mode: assert property (@(posedge clk) disable iff (rst)
    (!io_mode && $past(!io_mode) && $past(sys_addr_phase) && !$past(rst))
      |-> pin_oe == 16'hFFFF && pin_out == $past(sys_addr))
    else $error("Bus mode does not drive the address.");

  chk_narrow_bus: assert property (@(posedge clk) disable iff (rst)
    (!io_mode && !state_reg.wide_bus && !sys_addr_phase) |=> !io_mode |-> pin_oe == 16'hFFFF)
    else $error("Narrow bus released its address lines.");

  chk_ctrl_zero: assert property (@(posedge clk) disable iff (rst)
    (state_reg.bus_ctrl & ~gpio_pkg::BUS_CTRL_MASK) == 8'h00)
    else $error("Unimplemented control bits are set.");

  chk_bus_keeps: assert property (@(posedge clk) disable iff (rst)
    (!io_mode && !apb_access) |=> $stable(state_reg.low) && $stable(state_reg.high))
    else $error("Bus mode changed port registers.");

  chk_reset_dir: assert property (@(posedge clk)
    $fell(rst) |-> state_reg.low.dir == 8'hFF && state_reg.high.dir == 8'hFF
      && bus_enabled)
    else $error("Directions did not reset to input.");

  // Every pin, not only bit zero, follows its own direction and latch bit.
  for (genvar g = 0; g < 16; g++)
  begin : gen_pin_chk
    chk_pin_follow: assert property (@(posedge clk) disable iff (rst)
      ($past(io_mode) && io_mode)
        |-> pin_oe[g] == !$past(dir_all[g])
          && (!pin_oe[g] || pin_out[g] == $past(latch_all[g])))
      else $error("Pin does not follow its direction and latch bits.");
  end

  chk_pin_read: assert property (@(posedge clk) disable iff (rst)
    (apb_access && !pwrite && paddr == gpio_pkg::ADDR_LOW_PINS)
      |=> pready && prdata[7:0] == $past(low_port_pins_in))
    else $error("Pin register read does not return the pin levels.");

  chk_high_readback: assert property (@(posedge clk) disable iff (rst)
    (apb_access && !pwrite && paddr == gpio_pkg::ADDR_HIGH_LATCH)
      |=> pready && prdata[7:0] == $past(state_reg.high.latch))
    else $error("High latch read does not return the latch.");

  chk_ctrl_write: assert property (@(posedge clk) disable iff (rst)
    (apb_access && pwrite && paddr == gpio_pkg::ADDR_BUS_CTRL)
      |=> state_reg.bus_ctrl == ($past(pwdata[7:0]) & gpio_pkg::BUS_CTRL_MASK))
    else $error("Control write kept an unimplemented bit.");

  // The status flag trails the mode bit by its one register stage.
  chk_bus_flag: assert property (@(posedge clk) disable iff (rst)
    bus_enabled == !$past(io_mode))
    else $error("Bus flag disagrees with the mode bit.");

  chk_wide_write: assert property (@(posedge clk) disable iff (rst)
    (!io_mode && state_reg.wide_bus && !sys_addr_phase && sys_write)
      |=> pin_oe == 16'hFFFF && pin_out == $past(sys_wdata))
    else $error("Wide bus write data is not on the pins.");

  chk_wide_read: assert property (@(posedge clk) disable iff (rst)
    (!io_mode && state_reg.wide_bus && !sys_addr_phase && !sys_write)
      |=> pin_oe == 16'h0000)
    else $error("Wide bus read phase still drives the pins.");

  // Skipped right after reset, while the capture register still held zero.
  chk_bus_sample: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> sys_rdata == $past(pins_in))
    else $error("Bus read data is not the sampled pin level.");

endmodule : dual_bus_shared_io_ports

// ---- design/gpio_pkg.sv ----
package gpio_pkg;

  // --------------------------------------------------------------------------
  // Register byte addresses on the APB slave.
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_LOW_PINS = 8'h00;
  localparam logic [7:0] ADDR_LOW_LATCH = 8'h04;
  localparam logic [7:0] ADDR_LOW_DIR = 8'h08;
  localparam logic [7:0] ADDR_HIGH_PINS = 8'h0C;
  localparam logic [7:0] ADDR_HIGH_LATCH = 8'h10;
  localparam logic [7:0] ADDR_HIGH_DIR = 8'h14;
  localparam logic [7:0] ADDR_BUS_CTRL = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;

  // --------------------------------------------------------------------------
  // Field positions of the memory bus control register.
  // --------------------------------------------------------------------------
  localparam int BUS_DIS_POS = 7;
  localparam int PGRM_POS = 6;
  localparam int WAIT_HI_POS = 5;
  localparam int WAIT_LO_POS = 4;
  localparam int WM_HI_POS = 1;
  localparam int WM_LO_POS = 0;
  localparam logic [7:0] BUS_CTRL_MASK = 8'hF3;

  // Field position of the bus-width select in the status/control register.
  localparam int WIDE_BUS_POS = 0;

  // --------------------------------------------------------------------------
  // Reset values.
  // --------------------------------------------------------------------------
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] BUS_CTRL_RESET = 8'h00;
  localparam logic [7:0] LATCH_POWER_ON = 8'h00;
  localparam logic WIDE_BUS_RESET = 1'b1;

  // APB access phase of a single register transfer.
  typedef enum logic [1:0]
  {
    APB_IDLE = 2'b00,
    APB_DONE = 2'b01
  } apb_state_t;

  // One 8-bit port's software-visible configuration.
  typedef struct packed
  {
    logic [7:0] latch;
    logic [7:0] dir;
  } port_cfg_t;

  // System bus drive request for one pin group.
  typedef struct packed
  {
    logic [15:0] out;
    logic [15:0] oe;
  } sysbus_drive_t;

endpackage : gpio_pkg

// ---- design/pin_mux.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Per-pin selection between port function and system bus function.
// ----------------------------------------------------------------------------
module pin_mux #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic io_mode,
  input wire logic [WIDTH-1:0] latch,
  input wire logic [WIDTH-1:0] dir,
  input wire logic [WIDTH-1:0] bus_out,
  input wire logic [WIDTH-1:0] bus_oe,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe
);

  typedef struct packed
  {
    logic [WIDTH-1:0] out;
    logic [WIDTH-1:0] oe;
  } mux_state_t;

  mux_state_t state_reg;
  mux_state_t state_next;

  // Each pin picks its source; the latch and direction bits are only read.
  always_comb
  begin
    state_next = state_reg;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (io_mode)
      begin
        state_next.out[i] = latch[i];
        state_next.oe[i] = ~dir[i];
      end
      else
      begin
        state_next.out[i] = bus_out[i];
        state_next.oe[i] = bus_oe[i];
      end
    end
  end

  // Pins come out of reset released, so nothing is driven before a choice.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign pin_out = state_reg.out;
  assign pin_oe = state_reg.oe;

endmodule : pin_mux

// ---- testbench/dual_bus_shared_io_ports_tb.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Bench for the shared port pair.
// ----------------------------------------------------------------
module dual_bus_shared_io_ports_tb;
  logic clk = 0;
  logic rst = 1;
  logic por = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wire logic [15:0] pin_in;
  wire logic [15:0] pin_out;
  wire logic [15:0] pin_oe;
  logic [15:0] ext = 16'h0000;
  logic [15:0] sys_addr = 16'h0000;
  logic [15:0] sys_wdata = 16'h0000;
  logic sys_addr_phase = 1;
  logic sys_write = 0;
  logic [15:0] sys_rdata;
  logic bus_enabled;
  logic [31:0] seed = 32'h0000_0060;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int n_checks = 0;
  int lat_m [2];
  int dir_m [2];
  int i;
  int p;
  int d;

  dual_bus_shared_io_ports dual_bus_shared_io_ports_inst (
    .clk(clk), .rst(rst), .por(por), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_port_pins_in(pin_in[7:0]),
    .low_port_pins_out(pin_out[7:0]), .low_port_pins_oe(pin_oe[7:0]),
    .high_port_pins_in(pin_in[15:8]), .high_port_pins_out(pin_out[15:8]),
    .high_port_pins_oe(pin_oe[15:8]), .sys_addr(sys_addr),
    .sys_wdata(sys_wdata), .sys_addr_phase(sys_addr_phase),
    .sys_write(sys_write), .sys_rdata(sys_rdata), .bus_enabled(bus_enabled)
  );

  pin_partner pin_partner_inst (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in)
  );

  // Half period of the 40 MHz clock.
  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // One APB transfer; an idle edge first keeps psel from being set twice.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    int k;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    chk("pready", 1, pready);
  endtask : apb

  task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0000_0000);
    chk(n, e, rd);
  endtask : rdchk

  // Pin drive in port mode, judged from the reference model alone.
  task pins_io();
    logic [15:0] oe_x;
    logic [15:0] lv_x;
    cyc(3);
    oe_x = ~{dir_m[1][7:0], dir_m[0][7:0]};
    lv_x = (oe_x & {lat_m[1][7:0], lat_m[0][7:0]}) | (~oe_x & ext);
    chk("pin_oe", oe_x, pin_oe);
    chk("pin_out", lv_x & oe_x, pin_out & oe_x);
    rdchk("lo_pins", gpio_pkg::ADDR_LOW_PINS, lv_x[7:0]);
    rdchk("hi_pins", gpio_pkg::ADDR_HIGH_PINS, lv_x[15:8]);
  endtask : pins_io

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 0;
    por <= 0;
    lat_m = '{gpio_pkg::LATCH_POWER_ON, gpio_pkg::LATCH_POWER_ON};
    dir_m = '{gpio_pkg::DIR_RESET, gpio_pkg::DIR_RESET};
    chk("bus_en", 1, bus_enabled);
    rdchk("lo_dir", gpio_pkg::ADDR_LOW_DIR, 32'h0000_00FF);
    rdchk("hi_dir", gpio_pkg::ADDR_HIGH_DIR, 32'h0000_00FF);
    rdchk("ctl", gpio_pkg::ADDR_BUS_CTRL, 32'h0000_0000);
    rdchk("status", gpio_pkg::ADDR_STATUS, 32'h0000_0003);
    // Bus mode: address phase, wide write data phase, then read phase.
    for (i = 0; i < 3; i++)
    begin
      sys_addr <= 16'(xs());
      sys_wdata <= 16'(xs());
      ext <= 16'(xs());
      sys_addr_phase <= (i == 0);
      sys_write <= (i == 1);
      cyc(3);
      chk("bus_oe", (i == 2) ? 0 : 32'h0000_FFFF, pin_oe);
      chk("bus_out", (i == 0) ? sys_addr : (i == 1) ? sys_wdata : 16'h0000, pin_out & pin_oe);
      if (i == 2)
        chk("sys_rdata", ext, sys_rdata);
    end
    // A narrow bus keeps the address on the pins through the data phase.
    apb(1, gpio_pkg::ADDR_STATUS, 32'h0000_0000);
    sys_write <= 1;
    cyc(3);
    chk("narrow_out", sys_addr, pin_out);
    chk("narrow_oe", 32'h0000_FFFF, pin_oe);
    // Port registers written in bus mode are stored but do not reach pins.
    for (p = 0; p < 2; p++)
    begin
      d = xs() & 255;
      lat_m[p] = d;
      dir_m[p] = 0;
      apb(1, p ? gpio_pkg::ADDR_HIGH_LATCH : gpio_pkg::ADDR_LOW_LATCH, d);
      apb(1, p ? gpio_pkg::ADDR_HIGH_DIR : gpio_pkg::ADDR_LOW_DIR, 0);
    end
    sys_addr_phase <= 1;
    cyc(3);
    chk("bus_keep", {16'h0000, sys_addr}, {pin_oe ^ 16'hFFFF, pin_out});
    rdchk("lo_lat", gpio_pkg::ADDR_LOW_LATCH, lat_m[0]);
    // Setting the bus-disable bit hands the pins to the ports.
    apb(1, gpio_pkg::ADDR_BUS_CTRL, 32'h0000_00FF);
    rdchk("ctl_mask", gpio_pkg::ADDR_BUS_CTRL, 32'h0000_00F3);
    chk("bus_off", 0, bus_enabled);
    rdchk("status_io", gpio_pkg::ADDR_STATUS, 32'h0000_0000);
    // Port mode, edge directions first, latch written by both addresses.
    for (i = 0; i < 6; i++)
    begin
      ext <= 16'(xs());
      for (p = 0; p < 2; p++)
      begin
        d = xs() & 255;
        lat_m[p] = d;
        if (i[0])
          apb(1, p ? gpio_pkg::ADDR_HIGH_LATCH : gpio_pkg::ADDR_LOW_LATCH, d);
        else
          apb(1, p ? gpio_pkg::ADDR_HIGH_PINS : gpio_pkg::ADDR_LOW_PINS, d);
        dir_m[p] = (i == 0) ? 0 : (i == 1) ? 255 : (xs() & 255);
        apb(1, p ? gpio_pkg::ADDR_HIGH_DIR : gpio_pkg::ADDR_LOW_DIR, dir_m[p]);
      end
      pins_io();
      rdchk("hi_lat", gpio_pkg::ADDR_HIGH_LATCH, lat_m[1]);
    end
    apb(0, 8'h20, 32'h0000_0000);
    chk("slverr", 1, err);
    chk("unmapped", 0, rd);
    // Warm reset keeps the latches; power-on reset clears them.
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk);
      rst <= 1;
      por <= i[0];
      cyc(5);
      rst <= 0;
      por <= 0;
      if (i == 1)
        lat_m = '{gpio_pkg::LATCH_POWER_ON, gpio_pkg::LATCH_POWER_ON};
      rdchk("rst_lat", gpio_pkg::ADDR_LOW_LATCH, lat_m[0]);
      rdchk("rst_hlat", gpio_pkg::ADDR_HIGH_LATCH, lat_m[1]);
      rdchk("rst_dir", gpio_pkg::ADDR_HIGH_DIR, 32'h0000_00FF);
      rdchk("rst_ctl", gpio_pkg::ADDR_BUS_CTRL, 32'h0000_0000);
      chk("rst_bus", 1, bus_enabled);
    end
    end_of_test();
  end

  // Watchdog well beyond the few hundred cycles that the run needs.
  initial
  begin
    #200000;
    bad_count++;
    end_of_test();
  end
endmodule : dual_bus_shared_io_ports_tb

// ---- testbench/pin_partner.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Board side of the sixteen shared pins.
// ----------------------------------------------------------------
module pin_partner (
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] ext,
  output logic [15:0] pin_in
);
  // A driven pin shows the device level, a released one the board level.
  // The board level is reshuffled by the bench so a stale value is never seen.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : pin_partner
